// ==== pss_fifo.sv ====
// synchronous valid/ready fifo with honest full and empty
`timescale 1ns/10ps
module pss_fifo #(
  parameter int WIDTH = 54,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] slots [0:DEPTH-1];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] fill;
  logic push;
  logic pop;

  assign in_ready = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = slots[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slots[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wp <= (wp == PW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == PW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : pss_fifo

// ==== pss_host.sv ====
// host bus model driving the synchronous pins
`timescale 1ns/10ps
module pss_host (
  // clock
  input wire logic clk,
  // pins toward the sram port
  output pss_pkg::pss_pins_s p
);
  // ==========================================================
  // one call is one cycle, launched 1 ns after the edge
  initial p = '1;
  task automatic go(input logic ps, cl, burst_advance, g, e, input logic [2:0] ce,
                    input logic [3:0] s, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 p = {a, d, ps, cl, burst_advance, ce, s, e, g};
  endtask : go
  // deselect load; unused lines wander instead of holding
  task automatic idle();
    go(0, 0, 1, 1, 1, 3'h6, 4'hf, ~p.addr, ~p.data);
  endtask : idle
  task automatic load(input logic [17:0] a);
    go(0, 1, 1, 1, 1, 3'h2, 4'hf, a, ~p.data);
  endtask : load
  task automatic step();
    go(1, 1, 0, 1, 1, 3'h6, 4'hf, ~p.addr, ~p.data);
  endtask : step
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic g, e,
                    input logic [3:0] s, input logic [2:0] ce);
    go(1, 0, 1, g, e, ce, s, a, d);
  endtask : wr
endmodule : pss_host

// ==== pss_mem.sv ====
// word array with per-lane writes and a registered read port
`timescale 1ns/10ps
module pss_mem #(
  parameter int AW = 18,
  parameter int LN = 4
) (
  // clock
  input wire logic clk,
  // access port, one read or one write per cycle
  input wire logic rd,
  input wire logic [LN-1:0] we,
  input wire logic [AW-1:0] addr,
  input wire logic [LN*8-1:0] wdata,
  output logic [LN*8-1:0] rdata
);
  // ==========================================================
  // storage, one byte bank per lane so each bank has a single writer; no reset
  for (genvar g = 0; g < LN; g++) begin : g_lane
    logic [7:0] bank [0:(1<<AW)-1];
    logic [7:0] q;

    always_ff @(posedge clk) begin
      if (we[g]) begin
        bank[addr] <= wdata[g*8 +: 8];
      end
      if (rd) begin
        q <= bank[addr];
      end
    end

    assign rdata[g*8 +: 8] = q;
  end
endmodule : pss_mem

// ==== pss_pkg.sv ====
// shared constants and carrier types for the pipelined sync sram port
package pss_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BURST_W = 2;
  localparam int WFIFO_DEPTH = 16;
  // ==========================================================
  // reset values of the flops, the all-lanes mask and the synchroniser depth
  localparam logic OE_N_RESET = 1'b1;
  localparam logic SLEEP_RESET = 1'b0;
  localparam logic [BURST_W-1:0] CNT_RESET = 2'h0;
  localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // registered copy of all synchronous pins except LINEAR_ORDER
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic proc_strobe_n;
    logic ctrl_strobe_n;
    logic advance_n;
    logic primary_cs_n;
    logic depth_hi;
    logic depth_lo_n;
    logic [LANES-1:0] lane_sel_n;
    logic byte_we_n;
    logic global_we_n;
  } pss_pins_s;

  // one queued array write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lanes;
  } pss_wr_s;

  localparam int WR_W = $bits(pss_wr_s);
endpackage : pss_pkg

// ==== pss_port.sv ====
// pipelined synchronous burst sram: pin sampling, burst counter, write queue, read pipe
`timescale 1ns/10ps
// Operation
// - every synchronous pin is registered on the rising clock edge
// - address and chip selects load only when a recognised strobe is sampled
// - registered address picks one of 256K words of 32 bits
// - low two address bits seed a 2-bit burst counter
// - counter steps once per edge with advance low during a burst
// - burst order selectable: interleaved or linear
// - reads pipelined through registered outputs, 3-1-1-1 burst timing
// - write starts once address, data and controls are registered; array write self-timed
// - a write covers any one to four byte lanes
// - a lane select writes only when byte write enable is low too
// - global write low writes all four lanes, ignoring lane controls
// - three chip selects; selected only when all three active with a strobe
// - output enable and sleep are asynchronous, taken in through three-flop synchronisers
// - primary and third select active low, second active high, sampled at loads
// - output enable low drives data, high releases bus; masked after deselect
// - sleep high enters a data-preserving idle state
module pss_port (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // address and strobes
  input wire logic [pss_pkg::ADDR_W-1:0] ADDR,
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic LINEAR_ORDER,
  // chip selects
  input wire logic PRIMARY_CHIP_SELECT_N,
  input wire logic DEPTH_SELECT_HIGH,
  input wire logic DEPTH_SELECT_LOW_N,
  // write controls
  input wire logic [pss_pkg::LANES-1:0] BYTE_LANE_SELECT_N,
  input wire logic BYTE_WRITE_ENABLE_N,
  input wire logic GLOBAL_WRITE_N,
  // data bus, split into in, out and enable
  input wire logic [pss_pkg::DATA_W-1:0] DQ_IN,
  output logic [pss_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_DRIVE_N,
  // asynchronous controls
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  // status
  output logic SLEEP_ACTIVE,
  output logic WRITE_BUSY
);
  // ==========================================================
  // burst address ordering
  // both orders wrap inside the aligned group of four words
  function automatic logic [pss_pkg::BURST_W-1:0] burst_lo(
    input logic linear,
    input logic [pss_pkg::BURST_W-1:0] start,
    input logic [pss_pkg::BURST_W-1:0] cnt
  );
    burst_lo = linear ? start + cnt : start ^ cnt;
  endfunction : burst_lo

  // ==========================================================
  // pin sampling
  pss_pkg::pss_pins_s pin_r;
  logic linear_r;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      // strobes and selects leave reset inactive, so no access is decoded
      pin_r.addr <= '0;
      pin_r.data <= '0;
      pin_r.proc_strobe_n <= 1'b1;
      pin_r.ctrl_strobe_n <= 1'b1;
      pin_r.advance_n <= 1'b1;
      pin_r.primary_cs_n <= 1'b1;
      pin_r.depth_hi <= 1'b0;
      pin_r.depth_lo_n <= 1'b1;
      pin_r.lane_sel_n <= pss_pkg::LANES_OFF_N;
      pin_r.byte_we_n <= 1'b1;
      pin_r.global_we_n <= 1'b1;
      linear_r <= 1'b0;
    end else begin
      pin_r.addr <= ADDR;
      pin_r.data <= DQ_IN;
      pin_r.proc_strobe_n <= PROCESSOR_ADDR_STROBE_N;
      pin_r.ctrl_strobe_n <= CONTROLLER_ADDR_STROBE_N;
      pin_r.advance_n <= BURST_ADVANCE_N;
      pin_r.primary_cs_n <= PRIMARY_CHIP_SELECT_N;
      pin_r.depth_hi <= DEPTH_SELECT_HIGH;
      pin_r.depth_lo_n <= DEPTH_SELECT_LOW_N;
      pin_r.lane_sel_n <= BYTE_LANE_SELECT_N;
      pin_r.byte_we_n <= BYTE_WRITE_ENABLE_N;
      pin_r.global_we_n <= GLOBAL_WRITE_N;
      linear_r <= LINEAR_ORDER;
    end
  end

  // ==========================================================
  // asynchronous controls: three flops, a change counts once stages two and three agree
  logic [pss_pkg::SYNC_STAGES-1:0] oe_sync;
  logic [pss_pkg::SYNC_STAGES-1:0] zz_sync;
  logic oe_n_f;
  logic zz_f;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      oe_sync <= {pss_pkg::SYNC_STAGES{pss_pkg::OE_N_RESET}};
      zz_sync <= {pss_pkg::SYNC_STAGES{pss_pkg::SLEEP_RESET}};
      oe_n_f <= pss_pkg::OE_N_RESET;
      zz_f <= pss_pkg::SLEEP_RESET;
    end else begin
      oe_sync <= {oe_sync[1:0], OUTPUT_ENABLE_N};
      zz_sync <= {zz_sync[1:0], SLEEP_REQUEST};
      if (oe_sync[1] == oe_sync[2]) begin
        oe_n_f <= oe_sync[2];
      end
      if (zz_sync[1] == zz_sync[2]) begin
        zz_f <= zz_sync[2];
      end
    end
  end

  // ==========================================================
  // strobe decode and burst state
  logic [pss_pkg::ADDR_W-1:0] base;
  logic [pss_pkg::BURST_W-1:0] cnt;
  logic selected;
  logic load_p;
  logic load_c;
  logic load;
  logic sel_new;
  logic next_selected;
  logic [pss_pkg::BURST_W-1:0] next_cnt;
  logic [pss_pkg::ADDR_W-1:0] next_base;
  logic [pss_pkg::ADDR_W-1:0] acc_addr;
  logic active;

  always_comb begin
    // processor strobe only counts with primary select low, and wins a tie
    load_p = !pin_r.proc_strobe_n && !pin_r.primary_cs_n;
    load_c = !load_p && !pin_r.ctrl_strobe_n;
    load = load_p || load_c;
    sel_new = !pin_r.primary_cs_n && pin_r.depth_hi && !pin_r.depth_lo_n;
    next_selected = load ? sel_new : selected;
    next_base = load ? pin_r.addr : base;
    if (load) begin
      next_cnt = pss_pkg::CNT_RESET;
    end else if (selected && !pin_r.advance_n) begin
      next_cnt = cnt + 1'b1;
    end else begin
      next_cnt = cnt;
    end
    acc_addr = {next_base[pss_pkg::ADDR_W-1:pss_pkg::BURST_W],
                burst_lo(linear_r, next_base[pss_pkg::BURST_W-1:0], next_cnt)};
    // sleep only blocks accesses; the array keeps its contents
    active = next_selected && !zz_f;
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      base <= '0;
      cnt <= pss_pkg::CNT_RESET;
      selected <= 1'b0;
    end else begin
      base <= next_base;
      cnt <= next_cnt;
      selected <= next_selected;
    end
  end

  // ==========================================================
  // write decode
  typedef enum {ACC_NONE, ACC_READ, ACC_WRITE} pss_acc_e;
  logic [pss_pkg::LANES-1:0] lanes;
  pss_acc_e acc_kind;
  logic is_write;
  logic is_read;

  always_comb begin
    if (!pin_r.global_we_n) begin
      lanes = pss_pkg::LANES_ALL;
    end else if (!pin_r.byte_we_n) begin
      lanes = ~pin_r.lane_sel_n;
    end else begin
      lanes = '0;
    end
    // a processor-strobe load is always a read on its first clock
    if (!active) begin
      acc_kind = ACC_NONE;
    end else if (!load_p && (lanes != '0)) begin
      acc_kind = ACC_WRITE;
    end else begin
      acc_kind = ACC_READ;
    end
    case (acc_kind)
      ACC_WRITE: begin
        is_write = 1'b1;
        is_read = 1'b0;
      end
      ACC_READ: begin
        is_write = 1'b0;
        is_read = 1'b1;
      end
      default: begin
        is_write = 1'b0;
        is_read = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // write queue; the array takes queued writes only in cycles with no read
  // each write cycle also drains one entry, so the queue never holds more than one
  pss_pkg::pss_wr_s wr_in;
  pss_pkg::pss_wr_s wr_out;
  logic wq_ready;
  logic wq_valid;
  logic wq_pop;

  assign wr_in = '{addr: acc_addr, data: pin_r.data, lanes: lanes};
  assign wq_pop = !is_read;

  pss_fifo #(
    .WIDTH(pss_pkg::WR_W),
    .DEPTH(pss_pkg::WFIFO_DEPTH)
  ) u_wq (
    .clk(REF_CLK),
    .rst_n(NRST),
    .in_valid(is_write),
    .in_ready(wq_ready),
    .in_data(wr_in),
    .out_valid(wq_valid),
    .out_ready(wq_pop),
    .out_data(wr_out)
  );

  // ==========================================================
  // array; its registered read word is the data bus output
  logic [pss_pkg::LANES-1:0] mem_we;
  logic [pss_pkg::ADDR_W-1:0] mem_addr;

  assign mem_we = (wq_valid && wq_pop) ? wr_out.lanes : '0;
  assign mem_addr = is_read ? acc_addr : wr_out.addr;

  pss_mem #(
    .AW(pss_pkg::ADDR_W),
    .LN(pss_pkg::LANES)
  ) u_mem (
    .clk(REF_CLK),
    .rd(is_read),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(wr_out.data),
    .rdata(DQ_OUT)
  );

  // ==========================================================
  // bus direction; the mask blocks a glitch read right after a deselect
  // phase tracks whether the previous clock was a real access
  typedef enum {PH_DESELECTED, PH_SELECTED} pss_phase_e;
  pss_phase_e phase;
  pss_phase_e next_phase;
  logic next_drive_n;

  always_comb begin
    next_phase = active ? PH_SELECTED : PH_DESELECTED;
    case (phase)
      PH_SELECTED: begin
        next_drive_n = !(is_read && !oe_n_f);
      end
      PH_DESELECTED: begin
        // first read clock after a deselect or sleep keeps the bus released
        next_drive_n = 1'b1;
      end
      default: begin
        next_drive_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      phase <= PH_DESELECTED;
      DQ_DRIVE_N <= 1'b1;
    end else begin
      phase <= next_phase;
      DQ_DRIVE_N <= next_drive_n;
    end
  end

  // ==========================================================
  // status
  // busy guards the drain policy; a write that meets it is dropped
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      SLEEP_ACTIVE <= pss_pkg::SLEEP_RESET;
      WRITE_BUSY <= 1'b0;
    end else begin
      SLEEP_ACTIVE <= zz_f;
      WRITE_BUSY <= !wq_ready;
    end
  end
endmodule : pss_port

// ==== pss_port_monitor.sv ====
// bound checker on the sram port pins
`timescale 1ns/10ps
module pss_port_monitor (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // sampled pins
  input wire logic PROCESSOR_ADDR_STROBE_N,
  input wire logic CONTROLLER_ADDR_STROBE_N,
  input wire logic BURST_ADVANCE_N,
  input wire logic PRIMARY_CHIP_SELECT_N,
  input wire logic DEPTH_SELECT_HIGH,
  input wire logic DEPTH_SELECT_LOW_N,
  input wire logic BYTE_WRITE_ENABLE_N,
  input wire logic GLOBAL_WRITE_N,
  // async pins and outputs
  input wire logic OUTPUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  input wire logic [pss_pkg::DATA_W-1:0] DQ_OUT,
  input wire logic DQ_DRIVE_N,
  input wire logic SLEEP_ACTIVE
);
  // ==========================================================
  // one clock domain
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic sel;
  assign sel = !PRIMARY_CHIP_SELECT_N && DEPTH_SELECT_HIGH && !DEPTH_SELECT_LOW_N;

  AST_RESET_QUIET: assert property (
    $rose(NRST) |-> DQ_DRIVE_N && !SLEEP_ACTIVE)
    else $error("outputs busy after reset");
  AST_OE_RELEASE: assert property (
    OUTPUT_ENABLE_N [*6] |=> DQ_DRIVE_N)
    else $error("bus driven with oe high");
  AST_WRITE_QUIET: assert property (
    (PROCESSOR_ADDR_STROBE_N && !CONTROLLER_ADDR_STROBE_N && sel && !GLOBAL_WRITE_N)
    |-> ##2 (DQ_DRIVE_N && $stable(DQ_OUT))) else $error("write disturbed read port");
  AST_FIRST_MASK: assert property (
    (!CONTROLLER_ADDR_STROBE_N && PRIMARY_CHIP_SELECT_N) ##1 (!PROCESSOR_ADDR_STROBE_N && sel)
    |-> ##2 DQ_DRIVE_N) else $error("no oe mask after deselect");
  AST_BURST_DRIVE: assert property (
    (!OUTPUT_ENABLE_N && !SLEEP_REQUEST) [*6] ##0 (!PROCESSOR_ADDR_STROBE_N && sel)
    ##1 (PROCESSOR_ADDR_STROBE_N && CONTROLLER_ADDR_STROBE_N && !BURST_ADVANCE_N
    && GLOBAL_WRITE_N && BYTE_WRITE_ENABLE_N) |-> ##2 !DQ_DRIVE_N) else $error("burst not driven");
  AST_SLEEP_IN: assert property (
    SLEEP_REQUEST [*6] |=> SLEEP_ACTIVE)
    else $error("sleep not entered");
  AST_SLEEP_OUT: assert property (
    !SLEEP_REQUEST [*6] |=> !SLEEP_ACTIVE)
    else $error("sleep not left");
  AST_SLEEP_IDLE: assert property (
    SLEEP_ACTIVE [*3] |=> DQ_DRIVE_N)
    else $error("bus driven while asleep");
endmodule : pss_port_monitor

bind pss_port pss_port_monitor u_mon (
  .REF_CLK(REF_CLK),
  .NRST(NRST),
  .PROCESSOR_ADDR_STROBE_N(PROCESSOR_ADDR_STROBE_N),
  .CONTROLLER_ADDR_STROBE_N(CONTROLLER_ADDR_STROBE_N),
  .BURST_ADVANCE_N(BURST_ADVANCE_N),
  .PRIMARY_CHIP_SELECT_N(PRIMARY_CHIP_SELECT_N),
  .DEPTH_SELECT_HIGH(DEPTH_SELECT_HIGH),
  .DEPTH_SELECT_LOW_N(DEPTH_SELECT_LOW_N),
  .BYTE_WRITE_ENABLE_N(BYTE_WRITE_ENABLE_N),
  .GLOBAL_WRITE_N(GLOBAL_WRITE_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .SLEEP_REQUEST(SLEEP_REQUEST),
  .DQ_OUT(DQ_OUT),
  .DQ_DRIVE_N(DQ_DRIVE_N),
  .SLEEP_ACTIVE(SLEEP_ACTIVE)
);

// ==== tb.sv ====
// self-checking bench for the pipelined sync sram port
`timescale 1ns/10ps
module tb;
  // ==========================================================
  // pins, bus and reference array
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic lin = 1'b0;
  logic oe_n = 1'b0;
  logic slp = 1'b0;
  logic drv_n, slp_act, busy;
  logic [31:0] dq_out, bus;
  logic [31:0] mem [262144];
  pss_pkg::pss_pins_s p;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int b;

  initial forever #2 clk = ~clk;
  assign bus = drv_n ? p.data : dq_out;
  pss_host host (.clk(clk), .p(p));
  pss_port DUT (
    .REF_CLK(clk), .NRST(nrst), .ADDR(p.addr), .PROCESSOR_ADDR_STROBE_N(p.proc_strobe_n),
    .CONTROLLER_ADDR_STROBE_N(p.ctrl_strobe_n), .BURST_ADVANCE_N(p.advance_n),
    .LINEAR_ORDER(lin), .PRIMARY_CHIP_SELECT_N(p.primary_cs_n), .DEPTH_SELECT_HIGH(p.depth_hi),
    .DEPTH_SELECT_LOW_N(p.depth_lo_n), .BYTE_LANE_SELECT_N(p.lane_sel_n),
    .BYTE_WRITE_ENABLE_N(p.byte_we_n), .GLOBAL_WRITE_N(p.global_we_n), .DQ_IN(bus),
    .DQ_OUT(dq_out), .DQ_DRIVE_N(drv_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .SLEEP_ACTIVE(slp_act), .WRITE_BUSY(busy)
  );

  // ==========================================================
  // compares and verdict
  task automatic cmp_word(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t word %h not %h", $time, g, e);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic g, e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t flag %b not %b", $time, g, e);
    end
  endtask : cmp_flag
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // writes update the reference only when really selected
  task automatic wr(input int a, input logic g, e, input logic [3:0] s, input logic [2:0] ce);
    logic [31:0] d;
    logic [3:0] ln;
    d = $urandom;
    host.wr(a[17:0], d, g, e, s, ce);
    ln = !g ? 4'hf : (!e ? ~s : 4'h0);
    if (ce == 3'h2 && !slp) begin
      for (int k = 0; k < 4; k++) begin
        if (ln[k]) mem[a][8*k+:8] = d[8*k+:8];
      end
    end
  endtask : wr
  // four-word burst; first word masked since it follows a deselect
  task automatic burst(input int a, input logic oe);
    logic [1:0] c;
    logic [17:0] w;
    host.load(a[17:0]);
    for (int i = 0; i < 5; i++) begin
      if (i < 3) host.step();
      else host.idle();
      c = 2'(i - 1);
      w = {a[17:2], lin ? a[1:0] + c : a[1:0] ^ c};
      if (i > 0) begin
        cmp_word(dq_out, mem[w]);
        cmp_flag(drv_n, i == 1 || !oe);
      end
    end
  endtask : burst

  initial begin
    void'($urandom(83));
    repeat (10) @(posedge clk);
    cmp_flag(drv_n, 1'b1);
    cmp_flag(slp_act, 1'b0);
    #1 nrst = 1'b1;
    for (int m = 0; m < 2; m++) begin
      lin = m[0];
      b = $urandom & 32'h3fffc;
      for (int j = 0; j < 4; j++) wr(b + j, 1'b0, 1'b1, 4'hf, 3'h2);
      repeat (2) wr(b + $urandom % 4, 1'b1, 1'b0, 4'($urandom % 15), 3'h2);
      for (int c = 0; c < 8; c++) wr(b + c % 4, 1'b0, 1'b1, 4'hf, 3'(c));
      wr(b + 1, 1'b1, 1'b1, 4'h0, 3'h2);
      cmp_flag(busy, 1'b0);
      repeat (3) host.idle();
      burst(b + $urandom % 4, 1'b1);
    end
    slp = 1'b1;
    repeat (6) host.idle();
    cmp_flag(slp_act, 1'b1);
    wr(b, 1'b0, 1'b1, 4'hf, 3'h2);
    slp = 1'b0;
    repeat (6) host.idle();
    cmp_flag(slp_act, 1'b0);
    burst(b, 1'b1);
    oe_n = 1'b1;
    repeat (6) host.idle();
    burst(b, 1'b0);
    cmp_flag(busy, 1'b0);
    print_verdict();
  end

  // hang guard, far above the roughly 90 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
endmodule : tb
